/* icg_core.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module icg_core (
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  input  wire logic                           ce,
  input  wire logic [icg_pkg::ICG_AW-1:0]     reg_addr,
  input  wire logic [icg_pkg::ICG_DW-1:0]     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [icg_pkg::ICG_DW-1:0]     reg_rdata,
  input  wire logic [icg_pkg::ICG_GPIO_N-1:0] gpio_in,
  input  wire logic                           timer_zero_overflow,
  input  wire logic                           pin_change_detect,
  input  wire logic                           periph_group_req,
  output logic                                irq_req,
  output logic      [icg_pkg::ICG_SRC_W-1:0]  irq_source
);
  import icg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [ICG_DW-1:0]    interrupt_control;
    logic [ICG_DW-1:0]    peripheral_interrupt_enable_zero;
    logic [ICG_DW-1:0]    irq_flags;
    logic [ICG_SEL_W-1:0] ext_pin_input_select;
    logic [ICG_DW-1:0]    rdata;
    logic                 irq;
    logic [ICG_SRC_W-1:0] src;
  } icg_state_s;

  icg_state_s st_q;
  icg_state_s st_d;

  logic [ICG_GPIO_N-1:0] gpio_sync;
  logic                  ext_level;
  logic                  ext_edge;
  logic                  global_irq_enable;
  logic                  peripheral_group_irq_enable;
  logic                  ext_pin_edge_select;
  logic [ICG_DW-1:0]     first_pending;
  logic                  group_pending;
  logic [ICG_DW-1:0]     pend_view;

  ////////////////////////////////////////////////////////////////////////////

  icg_sync #(
    .WIDTH (ICG_GPIO_N)
  ) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .ce       (ce),
    .async_in (gpio_in),
    .sync_out (gpio_sync)
  );

  // Changing the pin select may look like an edge on the new pin; software
  // should clear the external flag after moving the pin.
  assign ext_level = gpio_sync[st_q.ext_pin_input_select];

  icg_edge_detect u_edge (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .ce         (ce),
    .level_in   (ext_level),
    .rise_sel   (ext_pin_edge_select),
    .edge_pulse (ext_edge)
  );

  ////////////////////////////////////////////////////////////////////////////

  assign global_irq_enable =
    st_q.interrupt_control[ICG_CTRL_GLB_BIT];
  assign peripheral_group_irq_enable =
    st_q.interrupt_control[ICG_CTRL_GRP_BIT];
  assign ext_pin_edge_select =
    st_q.interrupt_control[ICG_CTRL_EDGE_BIT];

  // First-register sources need only their own enable here.
  assign first_pending = st_q.irq_flags
                       & st_q.peripheral_interrupt_enable_zero
                       & ICG_SRC_MASK;
  assign group_pending = periph_group_req
                       & peripheral_group_irq_enable;

  always_comb begin
    pend_view                   = first_pending;
    pend_view[ICG_PEND_GRP_BIT] = group_pending;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_d = st_q;

    if (reg_wr) begin
      unique case (reg_addr)
        ICG_ADDR_CTRL: begin
          st_d.interrupt_control = reg_wdata & ICG_CTRL_MASK;
        end
        ICG_ADDR_SRC_EN: begin
          // Unimplemented positions never store anything.
          st_d.peripheral_interrupt_enable_zero =
            reg_wdata & ICG_SRC_MASK;
        end
        ICG_ADDR_FLAGS: begin
          st_d.irq_flags = reg_wdata & ICG_SRC_MASK;
        end
        ICG_ADDR_PIN_SEL: begin
          st_d.ext_pin_input_select = reg_wdata[ICG_SEL_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Events are applied after the write so a set in the clearing cycle
    // is not lost; no enable takes part in setting a flag.
    if (timer_zero_overflow) begin
      st_d.irq_flags[ICG_TMR_BIT] = 1'b1;
    end
    if (pin_change_detect) begin
      st_d.irq_flags[ICG_PCHG_BIT] = 1'b1;
    end
    if (ext_edge) begin
      st_d.irq_flags[ICG_EXT_BIT] = 1'b1;
    end

    st_d.rdata = ICG_ZERO_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        ICG_ADDR_CTRL: begin
          st_d.rdata = st_q.interrupt_control;
        end
        ICG_ADDR_SRC_EN: begin
          st_d.rdata = st_q.peripheral_interrupt_enable_zero;
        end
        ICG_ADDR_FLAGS: begin
          st_d.rdata = st_q.irq_flags;
        end
        ICG_ADDR_PIN_SEL: begin
          st_d.rdata = {{(ICG_DW-ICG_SEL_W){1'b0}},
                        st_q.ext_pin_input_select};
        end
        ICG_ADDR_PEND: begin
          st_d.rdata = pend_view;
        end
        default: begin
          st_d.rdata = ICG_ZERO_BYTE;
        end
      endcase
    end

    // The request is held off entirely while the global enable is low.
    st_d.irq = global_irq_enable
             & ((|first_pending) | group_pending);

    // Fixed priority picks which source the core should service first.
    if (first_pending[ICG_EXT_BIT]) begin
      st_d.src = ICG_SRC_EXT;
    end else if (first_pending[ICG_TMR_BIT]) begin
      st_d.src = ICG_SRC_TMR;
    end else if (first_pending[ICG_PCHG_BIT]) begin
      st_d.src = ICG_SRC_PCHG;
    end else begin
      st_d.src = ICG_SRC_GROUP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q.interrupt_control                <= ICG_CTRL_RST;
      st_q.peripheral_interrupt_enable_zero <= ICG_SRC_EN_RST;
      st_q.irq_flags                        <= ICG_FLAGS_RST;
      st_q.ext_pin_input_select             <= ICG_PIN_SEL_RST;
      st_q.rdata                            <= ICG_ZERO_BYTE;
      st_q.irq                              <= 1'b0;
      st_q.src                              <= ICG_SRC_EXT;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata  = st_q.rdata;
  assign irq_req    = st_q.irq;
  assign irq_source = st_q.src;

endmodule // icg_core

/* icg_pkg.sv */
// Function
// - Global enable gates every interrupt request.
// - Group enable gates all peripheral-group requests.
// - Edge select: 1 rising, 0 falling.
// - Flags set regardless of any enable.
// - Enable bit 5 gates timer overflow.
// - Enable bit 4 gates pin change.
// - Enable bit 0 gates external pin.
// - Enable bits 7-6, 3-1 read zero.
// - First-register sources skip group enable.
// - Pin-select register chooses external interrupt pin.
package icg_pkg;

  localparam int unsigned ICG_AW     = 3;
  localparam int unsigned ICG_DW     = 8;
  localparam int unsigned ICG_GPIO_N = 8;
  localparam int unsigned ICG_SEL_W  = 3;
  localparam int unsigned ICG_SRC_W  = 2;

  ////////////////////////////////////////////////////////////////////////////

  localparam logic [ICG_AW-1:0] ICG_ADDR_CTRL    = 3'h0;
  localparam logic [ICG_AW-1:0] ICG_ADDR_SRC_EN  = 3'h1;
  localparam logic [ICG_AW-1:0] ICG_ADDR_FLAGS   = 3'h2;
  localparam logic [ICG_AW-1:0] ICG_ADDR_PIN_SEL = 3'h3;
  localparam logic [ICG_AW-1:0] ICG_ADDR_PEND    = 3'h4;

  ////////////////////////////////////////////////////////////////////////////

  localparam int unsigned ICG_CTRL_GLB_BIT  = 7;
  localparam int unsigned ICG_CTRL_GRP_BIT  = 6;
  localparam int unsigned ICG_CTRL_EDGE_BIT = 0;
  localparam int unsigned ICG_TMR_BIT       = 5;
  localparam int unsigned ICG_PCHG_BIT      = 4;
  localparam int unsigned ICG_EXT_BIT       = 0;
  localparam int unsigned ICG_PEND_GRP_BIT  = 7;

  localparam logic [ICG_DW-1:0] ICG_CTRL_MASK = 8'hC1;
  localparam logic [ICG_DW-1:0] ICG_SRC_MASK  = 8'h31;

  ////////////////////////////////////////////////////////////////////////////

  localparam logic [ICG_DW-1:0]    ICG_CTRL_RST    = 8'h00;
  localparam logic [ICG_DW-1:0]    ICG_SRC_EN_RST  = 8'h00;
  localparam logic [ICG_DW-1:0]    ICG_FLAGS_RST   = 8'h00;
  localparam logic [ICG_SEL_W-1:0] ICG_PIN_SEL_RST = 3'h0;
  localparam logic [ICG_DW-1:0]    ICG_ZERO_BYTE   = 8'h00;

  localparam logic [ICG_SRC_W-1:0] ICG_SRC_EXT   = 2'h0;
  localparam logic [ICG_SRC_W-1:0] ICG_SRC_TMR   = 2'h1;
  localparam logic [ICG_SRC_W-1:0] ICG_SRC_PCHG  = 2'h2;
  localparam logic [ICG_SRC_W-1:0] ICG_SRC_GROUP = 2'h3;

endpackage

/* icg_sync.sv */
`timescale 1ns/100ps
module icg_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import icg_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } icg_sync_s;

  icg_sync_s st_q;
  icg_sync_s st_d;

  // Only the second stage is visible outside; the first may be metastable.
  always_comb begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule // icg_sync

/* icg_edge_detect.sv */
`timescale 1ns/100ps
module icg_edge_detect (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic level_in,
  input  wire logic rise_sel,
  output logic      edge_pulse
);
  import icg_pkg::*;

  typedef struct packed {
    logic prev;
    logic pulse;
  } icg_edge_s;

  icg_edge_s st_q;
  icg_edge_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = level_in;
    if (rise_sel) begin
      st_d.pulse = level_in & ~st_q.prev;
    end else begin
      st_d.pulse = ~level_in & st_q.prev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign edge_pulse = st_q.pulse;

endmodule // icg_edge_detect

/* icg_core_asserts.sv */
`timescale 1ns/100ps
module icg_chk (
  input wire logic                           clk_sys,
  input wire logic                           srst,
  input wire logic                           ce,
  input wire logic [icg_pkg::ICG_AW-1:0]     reg_addr,
  input wire logic [icg_pkg::ICG_DW-1:0]     reg_wdata,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [icg_pkg::ICG_DW-1:0]     reg_rdata,
  input wire logic [icg_pkg::ICG_GPIO_N-1:0] gpio_in,
  input wire logic                           timer_zero_overflow,
  input wire logic                           pin_change_detect,
  input wire logic                           periph_group_req,
  input wire logic                           irq_req,
  input wire logic [icg_pkg::ICG_SRC_W-1:0]  irq_source
);
  import icg_pkg::*;
  logic glb_q, grp_q, ten_q, pen_q, een_q;
  // The enables are mirrored from the bus so that no internal probe is needed.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {glb_q, grp_q, ten_q, pen_q, een_q} <= '0;
    end else if (ce && reg_wr && reg_addr == ICG_ADDR_CTRL) begin
      {glb_q, grp_q} <= reg_wdata[7:6];
    end else if (ce && reg_wr && reg_addr == ICG_ADDR_SRC_EN) begin
      {ten_q, pen_q, een_q} <= {reg_wdata[5:4], reg_wdata[0]};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_ev(ev, en);
    ce && ev && glb_q && en && !reg_wr ##1 ce |=> irq_req;
  endproperty
  chk_tmr_vector: assert property (p_ev(timer_zero_overflow, ten_q))
    else $error("timer event gave no request");
  chk_pchg_vector: assert property (p_ev(pin_change_detect, pen_q))
    else $error("pin change event gave no request");
  chk_glb_block: assert property (ce && !glb_q |=> !irq_req)
    else $error("request with global enable clear");
  chk_grp_block: assert property (
    ce && !grp_q && !(ten_q || pen_q || een_q) |=> !irq_req)
    else $error("request with no enabled source");
  chk_grp_vector: assert property (
    ce && glb_q && grp_q && periph_group_req && !reg_wr
    ##1 ce && periph_group_req |=> irq_req)
    else $error("group request not passed on");
  chk_pie_unused: assert property (
    ce && reg_rd && reg_addr == ICG_ADDR_SRC_EN
    |=> (reg_rdata & ~ICG_SRC_MASK) == 8'h00)
    else $error("unused enable bits read nonzero");
  chk_reset_clear: assert property (
    $fell(srst) |-> reg_rdata == 8'h00 && !irq_req)
    else $error("outputs not clear after reset");
  chk_ext_source: assert property (
    irq_req && irq_source == ICG_SRC_EXT |-> $past(een_q) && $past(glb_q))
    else $error("external request without its enables");
  cov_tmr: cover property (irq_req && irq_source == ICG_SRC_TMR);
  cov_grp: cover property (irq_req && irq_source == ICG_SRC_GROUP);
  cov_ext: cover property (irq_req && irq_source == ICG_SRC_EXT);
endmodule // icg_chk
bind icg_core icg_chk u_chk (.clk_sys(clk_sys), .srst(srst), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
  .timer_zero_overflow(timer_zero_overflow),
  .pin_change_detect(pin_change_detect),
  .periph_group_req(periph_group_req), .irq_req(irq_req),
  .irq_source(irq_source));

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
  import icg_pkg::*;
  logic                  clk_sys, srst, ce, reg_wr, reg_rd, tzo, pcd, grp;
  logic                  irq_req;
  logic [ICG_AW-1:0]     reg_addr;
  logic [ICG_DW-1:0]     reg_wdata, reg_rdata;
  logic [ICG_GPIO_N-1:0] gpio_in;
  logic [ICG_SRC_W-1:0]  irq_source;
  int                    err_count, checked;
  icg_core dut (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
    .timer_zero_overflow(tzo), .pin_change_detect(pcd),
    .periph_group_req(grp), .irq_req(irq_req), .irq_source(irq_source));
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp8(logic [ICG_DW-1:0] got, logic [ICG_DW-1:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t read %h, expected %h", $time, got, exp);
    end
  endtask
  // The request is a settled level, so it is checked a few edges later.
  task automatic chk_irq(logic req, logic [ICG_SRC_W-1:0] src);
    repeat (3) @(posedge clk_sys);
    #1;
    checked++;
    if (irq_req !== req || (req && irq_source !== src)) begin
      err_count++;
      $display("[ERR] %0t request %b source %h", $time, irq_req, irq_source);
    end
  endtask
  task automatic wr(logic [ICG_AW-1:0] a, logic [ICG_DW-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [ICG_AW-1:0] a, logic [ICG_DW-1:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp8(reg_rdata, exp);
  endtask
  task automatic pulse(logic t, logic p);
    @(posedge clk_sys);
    tzo <= t;
    pcd <= p;
    @(posedge clk_sys);
    tzo <= 1'b0;
    pcd <= 1'b0;
  endtask
  // Select changes may leave one stray flag, so wait, then clear flags.
  task automatic settle_clear();
    repeat (8) @(posedge clk_sys);
    wr(ICG_ADDR_FLAGS, 8'h00);
  endtask
  task automatic ext(int i, logic lvl, logic [ICG_DW-1:0] f, logic q);
    @(posedge clk_sys);
    gpio_in[i] <= lvl;
    repeat (8) @(posedge clk_sys);
    rd(ICG_ADDR_FLAGS, f);
    chk_irq(q, ICG_SRC_EXT);
    settle_clear();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    {srst, ce, reg_wr, reg_rd, tzo, pcd, grp} = 7'b1100000;
    reg_addr = '0;
    reg_wdata = '0;
    gpio_in = '0;
    err_count = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(ICG_AW'(a), 8'h00);
    wr(ICG_ADDR_SRC_EN, 8'hFF);
    rd(ICG_ADDR_SRC_EN, 8'h31);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    pulse(1'b1, 1'b1);
    wr(ICG_ADDR_SRC_EN, 8'h00);
    rd(ICG_ADDR_FLAGS, 8'h30);
    wr(ICG_ADDR_CTRL, 8'h80);
    chk_irq(1'b0, ICG_SRC_EXT);
    wr(ICG_ADDR_FLAGS, 8'h00);
    // With the clock enable low both the events and the strobe are lost.
    @(posedge clk_sys);
    ce <= 1'b0;
    pulse(1'b1, 1'b1);
    wr(ICG_ADDR_FLAGS, 8'h31);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(ICG_ADDR_FLAGS, 8'h00);
    wr(ICG_ADDR_SRC_EN, 8'h30);
    pulse(1'b1, 1'b1);
    chk_irq(1'b1, ICG_SRC_TMR);
    rd(ICG_ADDR_PEND, 8'h30);
    wr(ICG_ADDR_SRC_EN, 8'h10);
    chk_irq(1'b1, ICG_SRC_PCHG);
    wr(ICG_ADDR_CTRL, 8'h00);
    chk_irq(1'b0, ICG_SRC_EXT);
    wr(ICG_ADDR_SRC_EN, 8'h00);
    wr(ICG_ADDR_FLAGS, 8'h00);
    @(posedge clk_sys);
    grp <= 1'b1;
    wr(ICG_ADDR_CTRL, 8'h80);
    chk_irq(1'b0, ICG_SRC_GROUP);
    wr(ICG_ADDR_CTRL, 8'hC0);
    chk_irq(1'b1, ICG_SRC_GROUP);
    rd(ICG_ADDR_PEND, 8'h80);
    @(posedge clk_sys);
    grp <= 1'b0;
    wr(ICG_ADDR_CTRL, 8'hFF);
    rd(ICG_ADDR_CTRL, 8'hC1);
    wr(ICG_ADDR_PIN_SEL, 8'h02);
    wr(ICG_ADDR_CTRL, 8'h80);
    settle_clear();
    wr(ICG_ADDR_SRC_EN, 8'h01);
    ext(2, 1'b1, 8'h00, 1'b0);
    ext(2, 1'b0, 8'h01, 1'b1);
    ext(5, 1'b1, 8'h00, 1'b0);
    ext(5, 1'b0, 8'h00, 1'b0);
    wr(ICG_ADDR_CTRL, 8'h81);
    settle_clear();
    ext(2, 1'b1, 8'h01, 1'b1);
    ext(2, 1'b0, 8'h00, 1'b0);
    wr(ICG_ADDR_SRC_EN, 8'h00);
    ext(2, 1'b1, 8'h01, 1'b0);
    // A reset in mid-run must clear enables, flags and the request alike.
    wr(ICG_ADDR_SRC_EN, 8'h31);
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    rd(ICG_ADDR_CTRL, 8'h00);
    rd(ICG_ADDR_SRC_EN, 8'h00);
    rd(ICG_ADDR_FLAGS, 8'h00);
    chk_irq(1'b0, ICG_SRC_EXT);
    report_and_stop();
  end
endmodule // testbench
